// ### common/ccrt_defines.svh
`ifndef CCRT_DEFINES_SVH
`define CCRT_DEFINES_SVH

// ************************************************************
// Clock and base rates
// ************************************************************
`define CCRT_CLK_MHZ        200
`define CCRT_SLOW_BASE_DIV  266240
`define CCRT_FAST_BASE_DIV  16640
`define CCRT_FILTER_DIV     256
`define CCRT_INT_OSC_DIV    56
`define CCRT_DETECT_CYC     4096
`define CCRT_DETECT_EDGES   16

// ************************************************************
// Done strobe widths, in ns
// ************************************************************
`define CCRT_DONE_SLOW_NS   64000
`define CCRT_DONE_FAST_NS   4000

// ************************************************************
// Field values and reset defaults
// ************************************************************
`define CCRT_RATE_RESET     3'h7
`define CCRT_REF_RESET      1'h0
`define CCRT_POS_RESET      3'h0
`define CCRT_NEG_RESET      3'h1
`define CCRT_GAIN_RESET     3'h0
`define CCRT_BUF_RESET      1'h0
`define CCRT_GAIN_FIXED_MIN 3'h4
`define CCRT_REF2_PIN_A     3'h6
`define CCRT_REF2_PIN_B     3'h7
`define CCRT_EXC_MAX        4'ha
`define CCRT_CH_FULL        7
`define CCRT_CH_SMALL       4

`endif

// ### common/ccrt_pkg.sv
package ccrt_pkg;

  // Clock source modes
  typedef enum logic [1:0] {
    CCRT_CLK_INT    = 2'b00,
    CCRT_CLK_EXT    = 2'b01,
    CCRT_CLK_DETECT = 2'b10
  } ccrt_clk_mode_t;

  // One channel's settings: input control and setup
  typedef struct packed {
    logic       reference_two;
    logic [2:0] positive_input_select;
    logic [2:0] negative_input_select;
    logic       buf_en;
    logic [2:0] gain_sel;
    logic [2:0] rate_select;
  } ccrt_chan_cfg_t;

  // Decoded view of one channel
  typedef struct packed {
    logic       fixed_amp_stage;
    logic [1:0] programmable_amp_stage;
    logic [7:0] gain;
    logic       buffer_in_path;
    logic       inputs_ok;
    logic       slow_base;
    logic [1:0] rate_shift;
  } ccrt_chan_dec_t;

  // Scan states
  typedef enum logic [0:0] {
    CCRT_IDLE = 1'b0,
    CCRT_CONV = 1'b1
  } ccrt_state_t;

endpackage

// ### design/ccrt_chan_decode.sv
`include "ccrt_defines.svh"

module ccrt_chan_decode
  import ccrt_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input  ccrt_chan_cfg_t cfg, // Stored channel settings
  output ccrt_chan_dec_t dec  // Decoded channel view
);

  // ************************************************************
  // Gain composition and buffer
  // ************************************************************
  wire fixed_on = (cfg.gain_sel >= `CCRT_GAIN_FIXED_MIN); // RQ5
  wire [7:0] gain_val = 8'(8'h01 << cfg.gain_sel);        // RQ5
  // Buffer is forced in at 16x and above
  wire buf_in = fixed_on | cfg.buf_en;                    // RQ7

  // ************************************************************
  // Input availability
  // ************************************************************
  // Second reference takes over the pins of inputs six and seven
  wire pos_ref = cfg.reference_two &
                 (cfg.positive_input_select == `CCRT_REF2_PIN_A |
                  cfg.positive_input_select == `CCRT_REF2_PIN_B); // RQ8
  wire neg_ref = cfg.reference_two &
                 (cfg.negative_input_select == `CCRT_REF2_PIN_A |
                  cfg.negative_input_select == `CCRT_REF2_PIN_B); // RQ8
  // Small variant lacks inputs three to five
  wire pos_sm = SMALL_VARIANT & (cfg.positive_input_select >= 3'h3) &
                (cfg.positive_input_select <= 3'h5);              // RQ10
  wire neg_sm = SMALL_VARIANT & (cfg.negative_input_select >= 3'h3) &
                (cfg.negative_input_select <= 3'h5);              // RQ10

  // Rate field: top bit picks base, low bits pick divide by 8,4,2,1
  assign dec.slow_base              = ~cfg.rate_select[2];        // RQ2
  assign dec.rate_shift             = 2'h3 - cfg.rate_select[1:0]; // RQ2
  assign dec.fixed_amp_stage        = fixed_on;
  assign dec.programmable_amp_stage = cfg.gain_sel[1:0];          // RQ5
  assign dec.gain                   = gain_val;
  assign dec.buffer_in_path         = buf_in;
  assign dec.inputs_ok = ~(pos_ref | neg_ref | pos_sm | neg_sm);   // RQ9

endmodule // ccrt_chan_decode

// ### design/ccrt_rate_timer.sv
module ccrt_rate_timer (
  input  wire logic        clk,      // System clock
  input  wire logic        rst,      // Async reset, active high
  input  wire logic        restart,  // Clear count, start new period
  input  wire logic        mod_tick, // One modulator clock cycle
  input  wire logic [21:0] period,   // Modulator cycles per conversion
  output logic             done      // End of conversion pulse
);

  logic [21:0] cnt_ff;
  logic [21:0] nxt_cnt;
  logic        done_ff;
  logic        nxt_done;

  // ************************************************************
  // Period counter
  // ************************************************************
  wire last = mod_tick & (cnt_ff + 22'h1 >= period); // RQ16
  assign nxt_done = ~restart & last;                 // RQ16
  assign nxt_cnt  = restart ? 22'h0 :
                    last ? 22'h0 :
                    mod_tick ? cnt_ff + 22'h1 : cnt_ff;

  // Count register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= 22'h0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule // ccrt_rate_timer

// ### design/ccrt_top.sv
// Overview of operation
// RQ1: Odd external clock: bases clock/266240, clock/16640
// RQ2: Eight rates, base divided by 1,2,4,8
// RQ3: Each channel keeps its own rate
// RQ4: Scanning n channels divides per-channel rate
// RQ5: Gain is fixed stage times programmable stage
// RQ6: Each channel keeps its own gain
// RQ7: Buffer forced in at gain 16+
// RQ8: Reference select per channel, second blocks pins
// RQ9: Positive and negative input selector per channel
// RQ10: Seven channels, or four on small variant
// RQ11: Detect crystal, then stop internal oscillator
// RQ12: Sinc filter, mains rejection only slow rates
// RQ13: Filter frequencies scale with external clock
// RQ14: Two excitation currents, 100 to 1000 uA
// RQ15: Done strobe each period, 64 or 4 us
// RQ16: Count modulator cycles per conversion period
// RQ17: Reset gives fastest rate, first reference
`include "ccrt_defines.svh"

module ccrt_top
  import ccrt_pkg::*;
#(
  parameter bit          SMALL_VARIANT = 1'b0,
  parameter int unsigned SLOW_BASE     = `CCRT_SLOW_BASE_DIV,
  parameter int unsigned FAST_BASE     = `CCRT_FAST_BASE_DIV,
  parameter int unsigned INT_DIV       = `CCRT_INT_OSC_DIV,
  parameter int unsigned DETECT_CYC    = `CCRT_DETECT_CYC,
  parameter int unsigned DETECT_EDGES  = `CCRT_DETECT_EDGES,
  parameter int unsigned DONE_SLOW_NS  = `CCRT_DONE_SLOW_NS,
  parameter int unsigned DONE_FAST_NS  = `CCRT_DONE_FAST_NS
) (
  input  wire logic           clk,              // System clock, 200 MHz
  input  wire logic           rst,              // Async reset, active high
  input  wire ccrt_clk_mode_t clk_mode,         // Modulator clock source
  input  wire logic           xtal_pin_in,      // External clock pin
  input  wire logic           cfg_wr,           // Write strobe for settings
  input  wire logic [2:0]     cfg_ch,           // Channel written
  input  wire ccrt_chan_cfg_t cfg_data,         // Settings written
  input  wire logic [2:0]     rd_ch,            // Channel read back
  output ccrt_chan_cfg_t      rd_data,          // Read-back settings
  input  wire logic           run,              // Convert while high
  input  wire logic [2:0]     scan_last,        // Last channel of scan
  input  wire logic [3:0]     exc_a_code,       // Current A code
  input  wire logic [3:0]     exc_b_code,       // Current B code
  output logic [3:0]          excitation_current_a, // A in 100 uA units
  output logic [3:0]          excitation_current_b, // B in 100 uA units
  output logic                int_osc_en,       // Internal oscillator on
  output logic                xtal_detected,    // Crystal seen
  output logic                filter_tick,      // Filter output clock
  output logic [2:0]          conv_ch,          // Channel converting
  output ccrt_chan_dec_t      conv_dec,         // Its decoded settings
  output logic                result_valid,     // Result pulse
  output logic [2:0]          result_ch,        // Channel of result
  output logic                mains_reject_on,  // Mains rejection usable
  output logic                conversion_done_strobe_n // Done, active low
);

  // ************************************************************
  // Derived constants
  // ************************************************************
  localparam int unsigned CH_COUNT =
    SMALL_VARIANT ? `CCRT_CH_SMALL : `CCRT_CH_FULL;          // RQ10
  localparam int unsigned SLOW_CYC_RAW =
    DONE_SLOW_NS * `CCRT_CLK_MHZ / 1000;
  localparam int unsigned FAST_CYC_RAW =
    DONE_FAST_NS * `CCRT_CLK_MHZ / 1000;
  localparam int unsigned SLOW_CYC = SLOW_CYC_RAW < 1 ? 1 : SLOW_CYC_RAW;
  localparam int unsigned FAST_CYC = FAST_CYC_RAW < 1 ? 1 : FAST_CYC_RAW;
  localparam logic [2:0]  LAST_CH  = 3'(CH_COUNT - 1);

  // ************************************************************
  // Channel settings storage
  // ************************************************************
  ccrt_chan_cfg_t cfg_ff [`CCRT_CH_FULL];
  ccrt_chan_dec_t dec    [`CCRT_CH_FULL];
  ccrt_chan_cfg_t rd_ff;
  ccrt_chan_cfg_t reset_cfg;

  assign reset_cfg.reference_two         = `CCRT_REF_RESET;  // RQ17
  assign reset_cfg.positive_input_select = `CCRT_POS_RESET;
  assign reset_cfg.negative_input_select = `CCRT_NEG_RESET;
  assign reset_cfg.buf_en                = `CCRT_BUF_RESET;
  assign reset_cfg.gain_sel              = `CCRT_GAIN_RESET;
  assign reset_cfg.rate_select           = `CCRT_RATE_RESET; // RQ17

  // Writes to channels the variant lacks are dropped
  wire wr_ok = cfg_wr & (cfg_ch <= LAST_CH);                 // RQ10

  // One settings word and one decoder per channel
  for (genvar g = 0; g < `CCRT_CH_FULL; g++) begin : g_ch
    wire hit = wr_ok & (cfg_ch == 3'(g));
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cfg_ff[g] <= '{`CCRT_REF_RESET, `CCRT_POS_RESET, `CCRT_NEG_RESET,
                       `CCRT_BUF_RESET, `CCRT_GAIN_RESET, `CCRT_RATE_RESET}; // RQ17
      end else if (hit) begin
        cfg_ff[g] <= cfg_data;                               // RQ3 RQ6
      end
    end
    ccrt_chan_decode #(
      .SMALL_VARIANT(SMALL_VARIANT)
    ) u_dec (
      .cfg(cfg_ff[g]),
      .dec(dec[g])
    );
  end

  // Read-back register; unknown channels read as reset values
  wire [2:0] rd_idx = (rd_ch <= LAST_CH) ? rd_ch : 3'h0;
  wire       rd_hit = (rd_ch <= LAST_CH);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ff <= '{`CCRT_REF_RESET, `CCRT_POS_RESET, `CCRT_NEG_RESET,
                 `CCRT_BUF_RESET, `CCRT_GAIN_RESET, `CCRT_RATE_RESET};
    end else begin
      rd_ff <= rd_hit ? cfg_ff[rd_idx] : reset_cfg;
    end
  end
  assign rd_data = rd_ff;

  // ************************************************************
  // Modulator clock source
  // ************************************************************
  logic       xs1_ff;
  logic       xs2_ff;
  logic       xs3_ff;
  logic [7:0] div_ff;
  logic [12:0] win_ff;
  logic [7:0] edge_ff;
  logic       xtal_ff;

  // Pin passes two flops; edge found from second and third
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xs1_ff <= 1'b0;
      xs2_ff <= 1'b0;
      xs3_ff <= 1'b0;
    end else begin
      xs1_ff <= xtal_pin_in;
      xs2_ff <= xs1_ff;
      xs3_ff <= xs2_ff;
    end
  end
  wire ext_edge = xs2_ff & ~xs3_ff;

  // Internal oscillator stands in as a divider of the system clock
  wire int_wrap = (div_ff >= 8'(INT_DIV - 1));
  wire int_tick = int_osc_en & int_wrap;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= 8'h0;
    end else begin
      div_ff <= (int_wrap | ~int_osc_en) ? 8'h0 : div_ff + 8'h1;
    end
  end

  // Crystal detection: count pin edges over a fixed window
  wire win_end  = (win_ff >= 13'(DETECT_CYC - 1));
  wire detect   = (clk_mode == CCRT_CLK_DETECT);
  wire edges_ok = (edge_ff >= 8'(DETECT_EDGES));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_ff  <= 13'h0;
      edge_ff <= 8'h0;
      xtal_ff <= 1'b0;
    end else begin
      win_ff  <= (win_end | ~detect) ? 13'h0 : win_ff + 13'h1;
      edge_ff <= (win_end | ~detect) ? 8'h0 :
                 (ext_edge & ~edges_ok) ? edge_ff + 8'h1 : edge_ff;
      xtal_ff <= ~detect ? 1'b0 : win_end ? edges_ok : xtal_ff; // RQ11
    end
  end

  // Running from the crystal shuts the internal oscillator off
  wire use_ext = (clk_mode == CCRT_CLK_EXT) | (detect & xtal_ff); // RQ11
  assign int_osc_en    = ~use_ext;                              // RQ11
  assign xtal_detected = xtal_ff;

  // Every modulator cycle, from whichever source is live
  wire mod_tick = use_ext ? ext_edge : int_tick;                // RQ1

  // Filter runs at modulator/256, so its response tracks the clock
  logic [7:0] flt_ff;
  logic       flt_tick_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flt_ff      <= 8'h0;
      flt_tick_ff <= 1'b0;
    end else begin
      flt_ff      <= mod_tick ? flt_ff + 8'h1 : flt_ff;         // RQ13
      flt_tick_ff <= mod_tick & (flt_ff == 8'hff);              // RQ13
    end
  end
  assign filter_tick = flt_tick_ff;

  // ************************************************************
  // Scan sequence
  // ************************************************************
  ccrt_state_t state_ff;
  ccrt_state_t nxt_state;
  logic [2:0]  ch_ff;
  logic [2:0]  nxt_ch;
  logic        conv_done;

  wire [2:0] scan_end  = (scan_last > LAST_CH) ? LAST_CH : scan_last;
  wire [2:0] ch_next   = (ch_ff >= scan_end) ? 3'h0 : ch_ff + 3'h1; // RQ4
  wire       start_new = (state_ff == CCRT_IDLE) & run;

  // Scanned channels take turns, so each gets one result per n
  always_comb begin
    nxt_state = state_ff;
    nxt_ch    = ch_ff;
    unique case (state_ff)
      CCRT_IDLE: begin
        if (run) begin
          nxt_state = CCRT_CONV;
          nxt_ch    = 3'h0;
        end
      end
      CCRT_CONV: begin
        if (~run) begin
          nxt_state = CCRT_IDLE;
        end else if (conv_done) begin
          nxt_ch = ch_next;                                     // RQ4
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= CCRT_IDLE;
      ch_ff    <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      ch_ff    <= nxt_ch;
    end
  end

  // ************************************************************
  // Conversion period
  // ************************************************************
  // Period uses the converting channel's own rate setting
  ccrt_chan_dec_t cur;
  assign cur = dec[ch_ff];                                      // RQ3
  wire [21:0] base_cyc = cur.slow_base ? 22'(SLOW_BASE) : 22'(FAST_BASE); // RQ1
  wire [21:0] period   = base_cyc << cur.rate_shift;            // RQ2 RQ16

  // Channel change restarts the count with the new period
  wire restart = start_new | conv_done | (state_ff == CCRT_IDLE);

  ccrt_rate_timer u_timer (
    .clk     (clk),
    .rst     (rst),
    .restart (restart & ~conv_done | start_new),
    .mod_tick(mod_tick & (state_ff == CCRT_CONV)),
    .period  (period),
    .done    (conv_done)
  );

  // ************************************************************
  // Outputs and done strobe
  // ************************************************************
  logic [13:0]    pw_ff;
  logic           rv_ff;
  logic [2:0]     rch_ff;
  ccrt_chan_dec_t cdec_ff;
  logic           mains_ff;

  // Strobe width follows the rate of the channel that finished
  wire [13:0] pw_len = cur.slow_base ? 14'(SLOW_CYC) : 14'(FAST_CYC); // RQ15
  wire        done_ok = conv_done & (state_ff == CCRT_CONV);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pw_ff <= 14'h0;
    end else begin
      pw_ff <= done_ok ? pw_len :
               (pw_ff != 14'h0) ? pw_ff - 14'h1 : 14'h0;        // RQ15
    end
  end
  assign conversion_done_strobe_n = (pw_ff == 14'h0);           // RQ15

  // Result tag and live channel view
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rv_ff    <= 1'b0;
      rch_ff   <= 3'h0;
      cdec_ff  <= '0;
      mains_ff <= 1'b0;
    end else begin
      rv_ff    <= done_ok;                                      // RQ4
      rch_ff   <= done_ok ? ch_ff : rch_ff;
      cdec_ff  <= cur;                                          // RQ5 RQ7
      // Sinc notches land on mains only at the slow base
      mains_ff <= cur.slow_base;                                // RQ12
    end
  end
  assign result_valid    = rv_ff;
  assign result_ch       = rch_ff;
  assign conv_dec        = cdec_ff;
  assign conv_ch         = ch_ff;
  assign mains_reject_on = mains_ff;

  // ************************************************************
  // Excitation currents
  // ************************************************************
  logic [3:0] exa_ff;
  logic [3:0] exb_ff;
  // Codes above ten clamp at 1000 uA; zero is off
  wire [3:0] exa = (exc_a_code > `CCRT_EXC_MAX) ? `CCRT_EXC_MAX : exc_a_code;
  wire [3:0] exb = (exc_b_code > `CCRT_EXC_MAX) ? `CCRT_EXC_MAX : exc_b_code;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exa_ff <= 4'h0;
      exb_ff <= 4'h0;
    end else begin
      exa_ff <= exa;                                            // RQ14
      exb_ff <= exb;                                            // RQ14
    end
  end
  assign excitation_current_a = exa_ff;
  assign excitation_current_b = exb_ff;

endmodule // ccrt_top

// ### sim/ccrt_chk.sv
module ccrt_chk
  import ccrt_pkg::*;
(
  input wire logic           clk,                     // Clock
  input wire logic           rst,                     // Reset
  input wire ccrt_clk_mode_t clk_mode,                // Clock source
  input wire logic           run,                     // Scan enable
  input wire logic [3:0]     exc_a_code,              // Current code in
  input wire logic [3:0]     excitation_current_a,    // Current code out
  input wire logic           int_osc_en,              // Oscillator on
  input wire logic           xtal_detected,           // Crystal seen
  input wire logic           filter_tick,             // Filter clock
  input wire ccrt_chan_dec_t conv_dec,                // Channel decode
  input wire logic           result_valid,            // Result pulse
  input wire logic           conversion_done_strobe_n // Done, low
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Properties, one clock domain
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Filter clock never faster than once every nine clocks
  sequence s_filt_gap; !filter_tick [*8]; endsequence
  sequence s_done_start; result_valid ##0 !conversion_done_strobe_n; endsequence
  property p_gain; result_valid |-> conv_dec.gain ==
    (8'h1 << {conv_dec.fixed_amp_stage, conv_dec.programmable_amp_stage}); endproperty
  property p_buf; result_valid && conv_dec.fixed_amp_stage |-> conv_dec.buffer_in_path;
  endproperty
  property p_done; result_valid |-> s_done_start ##1 !result_valid; endproperty
  property p_strobe_cause; $fell(conversion_done_strobe_n) |-> result_valid; endproperty
  property p_osc_ext; clk_mode == CCRT_CLK_EXT |-> !int_osc_en; endproperty
  property p_osc_det; clk_mode == CCRT_CLK_DETECT && xtal_detected |-> !int_osc_en; endproperty
  property p_osc_int; clk_mode == CCRT_CLK_INT |-> int_osc_en; endproperty
  property p_exc; exc_a_code <= 4'ha |=> excitation_current_a == $past(exc_a_code); endproperty
  property p_exc_clamp; exc_a_code > 4'ha |=> excitation_current_a == 4'ha; endproperty
  property p_filter; filter_tick |=> s_filt_gap; endproperty
  // An aborted conversion must not leak a late result
  property p_abort; !run [*3] |-> !result_valid; endproperty
  a_gain: assert property (p_gain) else $error("gain not stage product");
  a_buf: assert property (p_buf) else $error("buffer not forced");
  a_done: assert property (p_done) else $error("done strobe missing");
  a_strobe_cause: assert property (p_strobe_cause) else $error("stray strobe");
  a_osc_ext: assert property (p_osc_ext) else $error("oscillator left on");
  a_osc_det: assert property (p_osc_det) else $error("oscillator on with crystal");
  a_osc_int: assert property (p_osc_int) else $error("oscillator off");
  a_exc: assert property (p_exc) else $error("current code wrong");
  a_exc_clamp: assert property (p_exc_clamp) else $error("current not clamped");
  a_filter: assert property (p_filter) else $error("filter clock too fast");
  a_abort: assert property (p_abort) else $error("result while idle");
endmodule // ccrt_chk

bind ccrt_top ccrt_chk u_chk (.clk(clk), .rst(rst), .clk_mode(clk_mode), .run(run),
  .exc_a_code(exc_a_code), .excitation_current_a(excitation_current_a),
  .int_osc_en(int_osc_en), .xtal_detected(xtal_detected), .filter_tick(filter_tick),
  .conv_dec(conv_dec), .result_valid(result_valid),
  .conversion_done_strobe_n(conversion_done_strobe_n));

// ### sim/testbench.sv
module testbench
  import ccrt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Shortened counts keep the slowest rate near a thousand clocks
  localparam int          SB = 64, FB = 16, ID = 2, DS = 50, DF = 10;
  localparam logic [13:0] RST_CFG = 14'h0087;
  logic           clk, rst, xtal_pin_in = 1'b0, cfg_wr, run, result_valid, int_osc_en;
  logic           xtal_detected, done_n, xt_on, mains_on;
  ccrt_clk_mode_t clk_mode;
  logic [2:0]     cfg_ch, rd_ch, scan_last, result_ch, conv_ch, rate [4];
  logic [3:0]     exc_a_code, exc_b_code, exc_a, exc_b;
  ccrt_chan_cfg_t cfg_data, rd_data, c, cfg [8];
  ccrt_chan_dec_t conv_dec;
  logic [31:0]    seed = 32'h1c;
  int             error_cnt = 0, tests_run = 0, cyc_cnt = 0, n, w, k;

  ccrt_top #(.SLOW_BASE(SB), .FAST_BASE(FB), .INT_DIV(ID), .DETECT_CYC(64),
    .DETECT_EDGES(4), .DONE_SLOW_NS(DS), .DONE_FAST_NS(DF)) DUT (.clk(clk), .rst(rst),
    .clk_mode(clk_mode), .xtal_pin_in(xtal_pin_in), .cfg_wr(cfg_wr), .cfg_ch(cfg_ch),
    .cfg_data(cfg_data), .rd_ch(rd_ch), .rd_data(rd_data), .run(run),
    .scan_last(scan_last), .exc_a_code(exc_a_code), .exc_b_code(exc_b_code),
    .excitation_current_a(exc_a), .excitation_current_b(exc_b), .int_osc_en(int_osc_en),
    .xtal_detected(xtal_detected), .filter_tick(), .conv_ch(conv_ch), .conv_dec(conv_dec),
    .result_valid(result_valid), .result_ch(result_ch), .mains_reject_on(mains_on),
    .conversion_done_strobe_n(done_n));

  // ************************************************************
  // Clock, crystal stand-in and run limit
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Crystal of six clocks period; stands still when switched off
  always begin
    repeat (3) @(posedge clk);
    #1;
    if (xt_on) xtal_pin_in = ~xtal_pin_in;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Clocks between results of one channel on the internal clock
  function automatic int per(logic [2:0] r);
    return ID * ((r[2] ? FB : SB) << (3 - r[1:0]));
  endfunction
  function automatic logic [13:0] exp_dec(ccrt_chan_cfg_t d);
    logic ok;
    ok = !(d.reference_two && (d.positive_input_select >= 3'h6 ||
      d.negative_input_select >= 3'h6));
    return {d.gain_sel[2], d.gain_sel[1:0], 8'h1 << d.gain_sel, d.gain_sel[2] | d.buf_en,
      ok, !d.rate_select[2]};
  endfunction
  task automatic tick(int m);
    repeat (m) @(posedge clk);
    #1;
  endtask
  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [2:0] ch, ccrt_chan_cfg_t d);
    cfg_wr = 1'b1;
    cfg_ch = ch;
    cfg_data = d;
    tick(1);
    cfg_wr = 1'b0;
    tick(1);
  endtask
  // Bounded wait for the next result; returns clocks waited
  task automatic wait_res(output int m);
    m = 0;
    do begin
      tick(1);
      m++;
    end while (result_valid !== 1'b1 && m < 5000);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {rst, cfg_wr, run, xt_on} = 4'h8;
    clk_mode = CCRT_CLK_INT;
    {cfg_ch, rd_ch, scan_last, exc_a_code, exc_b_code} = 17'h0;
    cfg_data = RST_CFG;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_ch = 3'(i);
      tick(2);
      check(rd_data, RST_CFG, "reset settings");
    end
    $display("test reset done");
    // Random settings everywhere; the eighth index is out of range
    for (int i = 0; i < 8; i++) begin
      cfg[i] = ccrt_chan_cfg_t'(rnd());
      wr(3'(i), cfg[i]);
    end
    for (int i = 0; i < 8; i++) begin
      rd_ch = 3'(i);
      tick(2);
      check(rd_data, (i < 7) ? cfg[i] : RST_CFG, "read back");
    end
    $display("test storage done");
    run = 1'b1;
    for (int g = 0; g < 8; g++) begin
      c = ccrt_chan_cfg_t'(rnd());
      c.gain_sel = 3'(g);
      c.rate_select = ~3'(g);
      if (g == 5) {c.reference_two, c.positive_input_select} = 4'he;
      wr(3'h0, c);
      wait_res(n);
      wait_res(n);
      check(n, per(c.rate_select), "period");
      check({conv_dec.fixed_amp_stage, conv_dec.programmable_amp_stage, conv_dec.gain,
        conv_dec.buffer_in_path, conv_dec.inputs_ok, conv_dec.slow_base},
        exp_dec(c), "decode");
      check(mains_on, !c.rate_select[2], "mains reject");
      w = 0;
      while (done_n === 1'b0 && w < 20000) begin
        w++;
        tick(1);
      end
      check(w, (c.rate_select[2] ? DF : DS) / 5, "strobe width");
    end
    $display("test rates done");
    scan_last = 3'h3;
    for (int i = 0; i < 4; i++) begin
      c = ccrt_chan_cfg_t'(rnd());
      c.rate_select = (i == 2) ? 3'h6 : 3'h7;
      rate[i] = c.rate_select;
      wr(3'(i), c);
    end
    wait_res(n);
    repeat (6) begin
      k = (int'(result_ch) + 1) % 4;
      wait_res(n);
      check(result_ch, k, "scan channel");
      check(n, per(rate[k]), "scan gap");
      check(conv_ch, (k + 1) % 4, "scan next");
    end
    $display("test scan done");
    run = 1'b0;
    scan_last = 3'h0;
    clk_mode = CCRT_CLK_EXT;
    xt_on = 1'b1;
    tick(2);
    run = 1'b1;
    wait_res(n);
    wait_res(n);
    check(n, FB * 6, "external period");
    check(int_osc_en, 1'b0, "osc ext");
    clk_mode = CCRT_CLK_DETECT;
    tick(200);
    check(xtal_detected, 1'b1, "crystal found");
    check(int_osc_en, 1'b0, "osc detect");
    xt_on = 1'b0;
    tick(200);
    check(xtal_detected, 1'b0, "crystal lost");
    check(int_osc_en, 1'b1, "osc back");
    $display("test clocks done");
    for (int i = 0; i < 16; i++) begin
      exc_a_code = 4'(i);
      exc_b_code = 4'(rnd());
      tick(2);
      check(exc_a, (i > 10) ? 10 : i, "current a");
      check(exc_b, (exc_b_code > 4'ha) ? 4'ha : exc_b_code, "current b");
    end
    $display("test currents done");
    run = 1'b0;
    finish_test();
  end
endmodule // testbench
